// ===== hw/epwm_pkg.sv
// Shared constants for the enhanced PWM unit: register offsets, field
// positions, reset values, timing counts and state encodings.
// Assumes a 40 MHz core clock and an 8-bit APB byte address.
package epwm_pkg;

    // ==================================================================
    // Register byte offsets (one 32-bit word each)
    localparam logic [7:0] EPWM_OFS_COUNT    = 8'h00;
    localparam logic [7:0] EPWM_OFS_TCTRL    = 8'h04;
    localparam logic [7:0] EPWM_OFS_PERIOD   = 8'h08;
    localparam logic [7:0] EPWM_OFS_DUTY     = 8'h0C;
    localparam logic [7:0] EPWM_OFS_SHADOW   = 8'h10;
    localparam logic [7:0] EPWM_OFS_MODE     = 8'h14;
    localparam logic [7:0] EPWM_OFS_SDCTRL   = 8'h18;
    localparam logic [7:0] EPWM_OFS_RESTART  = 8'h1C;
    localparam logic [7:0] EPWM_OFS_FLAGS    = 8'h20;
    localparam logic [7:0] EPWM_OFS_PINDIR   = 8'h24;

    // ==================================================================
    // Field positions
    localparam int EPWM_MODE_CFG_LSB   = 6;
    localparam int EPWM_MODE_DC_LSB    = 4;
    localparam int EPWM_SD_STATUS_BIT  = 7;
    localparam int EPWM_SD_SRC_LSB     = 4;
    localparam int EPWM_SD_AC_LSB      = 2;
    localparam int EPWM_SD_BD_LSB      = 0;
    localparam int EPWM_RS_ENABLE_BIT  = 7;
    localparam int EPWM_TC_RUN_BIT     = 2;
    localparam int EPWM_TC_POST_LSB    = 3;
    localparam int EPWM_FLAG_MATCH_BIT = 1;

    // ==================================================================
    // Reset values and timing counts
    localparam logic [7:0] EPWM_REG_RESET   = 8'h00;
    localparam logic [3:0] EPWM_DIR_RESET   = 4'hF;
    localparam logic [1:0] EPWM_LAST_PHASE  = 2'h3;
    localparam logic [3:0] EPWM_PRE4_LIMIT  = 4'h3;
    localparam logic [3:0] EPWM_PRE16_LIMIT = 4'hF;

    // ==================================================================
    // Output configurations and dead-band states
    typedef enum logic [1:0] {
        EPWM_CFG_SINGLE = 2'b00,
        EPWM_CFG_FWD    = 2'b01,
        EPWM_CFG_HALF   = 2'b10,
        EPWM_CFG_REV    = 2'b11
    } epwm_cfg_t;

    typedef enum logic [2:0] {
        EPWM_DB_LOW  = 3'b001,
        EPWM_DB_WAIT = 3'b010,
        EPWM_DB_HIGH = 3'b100
    } epwm_db_state_t;

endpackage

// ===== hw/epwm_timer.sv
// Period time base: instruction-cycle phase, prescaler, 8-bit count.
// Assumes run, prescale and period come from registers in the parent.
`timescale 1ns/100ps

module epwm_timer
    import epwm_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       rst_in,
    // Control
    input  wire logic       run_in,
    input  wire logic [1:0] prescale_in,
    input  wire logic [7:0] period_in,
    input  wire logic       cnt_wr_in,
    input  wire logic [7:0] cnt_wdata_in,
    // Time base
    output logic      [7:0] count_out,
    output logic      [1:0] phase_out,
    output logic            period_start_out
);

    typedef struct packed {
        logic [7:0] cnt;
        logic [1:0] phase;
        logic [3:0] pre;
        logic       start;
    } epwm_tmr_t;

    epwm_tmr_t  tmr_ff;
    epwm_tmr_t  nxt_tmr;
    logic [3:0] pre_limit;

    // ==================================================================
    // Count advance; the count wraps one tick after matching the period
    always_comb
    begin
        nxt_tmr       = tmr_ff;
        nxt_tmr.start = 1'b0;
        case (prescale_in)
            2'b00:   pre_limit = 4'h0;
            2'b01:   pre_limit = EPWM_PRE4_LIMIT;
            default: pre_limit = EPWM_PRE16_LIMIT;
        endcase
        if (run_in)
        begin
            nxt_tmr.phase = tmr_ff.phase + 2'd1;
            if (tmr_ff.phase == EPWM_LAST_PHASE)
            begin
                if (tmr_ff.pre >= pre_limit)
                begin
                    nxt_tmr.pre = 4'h0;
                    if (tmr_ff.cnt == period_in) // RL2 RL20
                    begin
                        nxt_tmr.cnt   = 8'h00;
                        nxt_tmr.start = 1'b1;
                    end
                    else
                        nxt_tmr.cnt = tmr_ff.cnt + 8'd1;
                end
                else
                    nxt_tmr.pre = tmr_ff.pre + 4'd1;
            end
        end
        // Software write wins over the advance
        if (cnt_wr_in)
            nxt_tmr.cnt = cnt_wdata_in;
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
            tmr_ff <= '0;
        else
            tmr_ff <= nxt_tmr;
    end

    assign count_out        = tmr_ff.cnt;
    assign phase_out        = tmr_ff.phase;
    assign period_start_out = tmr_ff.start;

    // ==================================================================
    // New period begins only from a period match
    chk_period_wrap: assert property (@(posedge core_clk_in) // RL20
        disable iff (rst_in)
        tmr_ff.start |-> tmr_ff.cnt == 8'h00 &&
            $past(tmr_ff.cnt) == $past(period_in))
        else $error("period start without period match");

endmodule // epwm_timer

// ===== hw/epwm_deadband.sv
// Dead-band delay: delays a rising edge by delay*4 core clocks, passes a
// falling edge after one clock. Assumes delay counts instruction cycles.
`timescale 1ns/100ps

module epwm_deadband
    import epwm_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       rst_in,
    // Drive request and delay
    input  wire logic       level_in,
    input  wire logic [6:0] delay_in,
    // Delayed drive
    output logic            level_out
);

    typedef struct packed {
        epwm_db_state_t st;
        logic [8:0]     cnt;
        logic           out;
    } epwm_db_t;

    epwm_db_t db_ff;
    epwm_db_t nxt_db;

    // ==================================================================
    // Only turn-on is delayed, so the two switches never overlap
    always_comb
    begin
        nxt_db = db_ff;
        case (db_ff.st)
            EPWM_DB_LOW:
            begin
                nxt_db.out = 1'b0;
                if (level_in && delay_in == 7'h00)
                begin
                    nxt_db.st  = EPWM_DB_HIGH;
                    nxt_db.out = 1'b1;
                end
                else if (level_in) // RL6
                begin
                    nxt_db.st  = EPWM_DB_WAIT;
                    nxt_db.cnt = {delay_in, 2'b00} - 9'd1;
                end
            end
            EPWM_DB_WAIT:
            begin
                if (!level_in)
                    nxt_db.st = EPWM_DB_LOW;
                else if (db_ff.cnt == 9'h000)
                begin
                    nxt_db.st  = EPWM_DB_HIGH;
                    nxt_db.out = 1'b1;
                end
                else
                    nxt_db.cnt = db_ff.cnt - 9'd1;
            end
            EPWM_DB_HIGH:
            begin
                if (!level_in)
                begin
                    nxt_db.st  = EPWM_DB_LOW;
                    nxt_db.out = 1'b0;
                end
            end
            default:
            begin
                nxt_db.st  = EPWM_DB_LOW;
                nxt_db.out = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
            db_ff <= '{st: EPWM_DB_LOW, cnt: 9'h000, out: 1'b0};
        else
            db_ff <= nxt_db;
    end

    assign level_out = db_ff.out;

    // ==================================================================
    sequence db_rise_s;
        $rose(level_in) && delay_in != 7'h00 && db_ff.st == EPWM_DB_LOW;
    endsequence

    chk_db_holdoff: assert property (@(posedge core_clk_in) // RL6
        disable iff (rst_in)
        db_rise_s |=> !level_out [*4])
        else $error("dead band turned on early");

    chk_db_fall: assert property (@(posedge core_clk_in) // RL6
        disable iff (rst_in)
        !level_in |=> !level_out)
        else $error("dead band delayed turn off");

endmodule // epwm_deadband

// ===== hw/epwm_core.sv
// Enhanced PWM unit with dead band, auto-shutdown and auto-restart, with
// an APB register slave. Assumes pins pass through external tri-state
// buffers driven from pin_level_out and pin_oe_out.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps

// How it works
// RL1 - Software makes every used PWM pin an input before setup.
// RL2 - The period register sets the PWM period length.
// RL3 - Mode bits 7:6 pick output configuration and steering direction.
// RL4 - Mode bits 3:0 pick the active polarity of each pin pair.
// RL5 - Duty is the 8-bit duty register plus mode bits 5:4.
// RL6 - Half-bridge mode delays turn-on by the 7-bit dead-band count.
// RL7 - Shutdown control bits 6:4 choose the shutdown trigger sources.
// RL8 - In shutdown each pin pair goes to its chosen shutdown state.
// RL9 - Software sets the shutdown status bit during setup.
// RL10 - Restart-enable bit 7 lets shutdown status clear on its own.
// RL11 - Software clears match flag, sets prescale, then starts the timer.
// RL12 - Software waits for the match flag before enabling pin outputs.
// RL13 - Software clears shutdown status after enabling the pins.
// RL14 - Reset makes all pins inputs and restores register reset values.
// RL15 - Small package ignores pair B/D state and dead-band bits.
// RL16 - Source codes: none, comp1, comp2, either, pin, pin plus comps.
// RL17 - Pair state 00 drives low, 01 drives high, 1x floats.
// RL18 - Status set by an event shuts whole periods; resume at period start.
// RL19 - Writes to shutdown status are ignored while the trigger persists.
// RL20 - Period match resets the count and raises the match flag.
module epwm_core
    import epwm_pkg::*;
#(
    parameter bit SMALL_PACKAGE = 1'b0
)
(
    // Clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Shutdown sources
    input  wire logic        comp1_in,
    input  wire logic        comp2_in,
    input  wire logic        fault_n_in,
    // Bridge pins, order a, b, c, d
    output logic      [3:0]  pin_level_out,
    output logic      [3:0]  pin_oe_out
);

    typedef struct packed {
        logic [6:0]  tctrl;
        logic [7:0]  period;
        logic [7:0]  duty_hi;
        logic [7:0]  shadow_hi;
        logic [1:0]  shadow_lo;
        logic [7:0]  mode;
        logic [2:0]  sd_src;
        logic [1:0]  sd_ac;
        logic [1:0]  sd_bd;
        logic        sd_status;
        logic        restart_en;
        logic [6:0]  dly;
        logic        match_flag;
        logic [3:0]  dir;
        logic        hold_shut;
        logic [3:0]  pins;
        logic [3:0]  oe;
        logic [31:0] rdata;
    } epwm_state_t;

    epwm_state_t st_ff;
    epwm_state_t nxt_st;

    logic [7:0]  tmr_count;
    logic [1:0]  tmr_phase;
    logic        period_start;
    logic        wr_en;
    logic        cnt_wr;
    logic        sd_cond;
    logic        pwm_on;
    logic        pwm_raw;
    logic        db_a;
    logic        db_b;
    logic        shut;
    logic [6:0]  dly_eff;
    logic [3:0]  act;
    logic [3:0]  inv;
    epwm_cfg_t   cfg;

    // ==================================================================
    // Decoding helpers
    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            EPWM_OFS_COUNT, EPWM_OFS_TCTRL, EPWM_OFS_PERIOD,
            EPWM_OFS_DUTY, EPWM_OFS_SHADOW, EPWM_OFS_MODE,
            EPWM_OFS_SDCTRL, EPWM_OFS_RESTART, EPWM_OFS_FLAGS,
            EPWM_OFS_PINDIR: is_mapped = 1'b1;
            default:         is_mapped = 1'b0;
        endcase
    endfunction

    // Fault pin is active low; combined sources are ORed
    function automatic logic src_active(input logic [2:0] src,
                                        input logic       c1,
                                        input logic       c2,
                                        input logic       flt_n);
        src_active = (src[0] & c1) | (src[1] & c2) | (src[2] & ~flt_n);
    endfunction

    // Pair shutdown level and drive enable
    function automatic logic [1:0] pair_state(input logic [1:0] code);
        case (code)
            2'b00:   pair_state = 2'b10;
            2'b01:   pair_state = 2'b11;
            default: pair_state = 2'b00;
        endcase
    endfunction

    // ==================================================================
    // APB handshake: zero wait states, error on unmapped addresses
    assign wr_en       = psel_in & penable_in & pwrite_in &
                         is_mapped(paddr_in);
    assign cnt_wr      = wr_en && paddr_in == EPWM_OFS_COUNT;
    assign pready_out  = psel_in & penable_in;
    assign pslverr_out = psel_in & penable_in & ~is_mapped(paddr_in);
    assign prdata_out  = st_ff.rdata;

    // ==================================================================
    // Time base
    epwm_timer u_timer (
        .core_clk_in      (core_clk_in),
        .rst_in           (rst_in),
        .run_in           (st_ff.tctrl[EPWM_TC_RUN_BIT]),
        .prescale_in      (st_ff.tctrl[1:0]),
        .period_in        (st_ff.period),
        .cnt_wr_in        (cnt_wr),
        .cnt_wdata_in     (pwdata_in[7:0]),
        .count_out        (tmr_count),
        .phase_out        (tmr_phase),
        .period_start_out (period_start)
    );

    // ==================================================================
    // Modulation: duty compared against count plus instruction phase
    assign cfg     = epwm_cfg_t'(st_ff.mode[7:EPWM_MODE_CFG_LSB]); // RL3
    assign pwm_on  = st_ff.mode[3:2] == 2'b11;
    assign pwm_raw = pwm_on &&
        {tmr_count, tmr_phase} < {st_ff.shadow_hi, st_ff.shadow_lo}; // RL5
    assign dly_eff = SMALL_PACKAGE ? 7'h00 : st_ff.dly; // RL15
    assign sd_cond = src_active(st_ff.sd_src, comp1_in, comp2_in,
                                fault_n_in); // RL7 RL16
    assign shut    = st_ff.sd_status | st_ff.hold_shut;

    // Complementary half-bridge legs, each with delayed turn-on
    epwm_deadband u_db_a (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .level_in    (pwm_raw),
        .delay_in    (dly_eff),
        .level_out   (db_a)
    );

    epwm_deadband u_db_b (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .level_in    (pwm_on & ~pwm_raw),
        .delay_in    (dly_eff),
        .level_out   (db_b)
    );

    // ==================================================================
    // Active levels per configuration, then pair polarity
    always_comb
    begin
        act = 4'b0000;
        case (cfg) // RL3
            EPWM_CFG_SINGLE: act = {3'b000, pwm_raw};
            EPWM_CFG_FWD:    act = {pwm_raw, 2'b00, pwm_on};
            EPWM_CFG_HALF:   act = {2'b00, db_b, db_a}; // RL6
            EPWM_CFG_REV:    act = {1'b0, pwm_on, pwm_raw, 1'b0};
            default:         act = 4'b0000;
        endcase
        // Low-active pair is inverted; pin order is d, c, b, a
        inv = {st_ff.mode[0], st_ff.mode[1], st_ff.mode[0], st_ff.mode[1]};
        if (!pwm_on)
            inv = 4'b0000;
    end

    // ==================================================================
    // Register file, shutdown control and pin drive
    always_comb
    begin
        logic [1:0] ac_drv;
        logic [1:0] bd_drv;
        logic [7:0] wb;
        ac_drv = pair_state(st_ff.sd_ac);
        bd_drv = pair_state(st_ff.sd_bd);
        wb     = pwdata_in[7:0];
        nxt_st = st_ff;

        // Period start loads the duty shadow and raises the match flag
        if (period_start)
        begin
            nxt_st.shadow_hi = st_ff.duty_hi; // RL5
            nxt_st.shadow_lo = st_ff.mode[5:EPWM_MODE_DC_LSB];
        end

        if (wr_en)
        begin
            case (paddr_in)
                EPWM_OFS_TCTRL:   nxt_st.tctrl   = wb[6:0];
                EPWM_OFS_PERIOD:  nxt_st.period  = wb; // RL2
                EPWM_OFS_DUTY:    nxt_st.duty_hi = wb;
                EPWM_OFS_MODE:    nxt_st.mode    = wb; // RL3 RL4
                EPWM_OFS_SDCTRL:
                begin
                    nxt_st.sd_src = wb[6:EPWM_SD_SRC_LSB];
                    nxt_st.sd_ac  = wb[3:EPWM_SD_AC_LSB];
                    nxt_st.sd_bd  = SMALL_PACKAGE ? 2'b00 :
                                    wb[1:EPWM_SD_BD_LSB]; // RL15
                    if (!sd_cond) // RL19
                        nxt_st.sd_status = wb[EPWM_SD_STATUS_BIT];
                end
                EPWM_OFS_RESTART:
                begin
                    nxt_st.restart_en = wb[EPWM_RS_ENABLE_BIT];
                    nxt_st.dly = SMALL_PACKAGE ? 7'h00 : wb[6:0]; // RL15
                end
                EPWM_OFS_FLAGS:
                    nxt_st.match_flag = wb[EPWM_FLAG_MATCH_BIT];
                EPWM_OFS_PINDIR:  nxt_st.dir     = wb[3:0];
                default:          nxt_st.dir     = st_ff.dir;
            endcase
        end
        else if (st_ff.restart_en && !sd_cond)
            nxt_st.sd_status = 1'b0; // RL10

        // Hardware sets win over software clears
        if (period_start)
            nxt_st.match_flag = 1'b1; // RL20
        if (sd_cond)
            nxt_st.sd_status = 1'b1; // RL18

        // Whole periods stay shut; release only at a period start
        if (period_start)
            nxt_st.hold_shut = st_ff.sd_status; // RL18
        else
            nxt_st.hold_shut = st_ff.hold_shut | st_ff.sd_status;

        // Pins: normal drive, or pair shutdown state
        nxt_st.pins = act ^ inv; // RL4
        nxt_st.oe   = ~st_ff.dir;
        if (shut && pwm_on) // RL8 RL17
        begin
            nxt_st.pins = {bd_drv[0], ac_drv[0], bd_drv[0], ac_drv[0]};
            nxt_st.oe   = ~st_ff.dir &
                {bd_drv[1], ac_drv[1], bd_drv[1], ac_drv[1]};
        end

        // Read data captured in the setup phase
        nxt_st.rdata = 32'h0000_0000;
        if (psel_in && !penable_in && !pwrite_in)
        begin
            case (paddr_in)
                EPWM_OFS_COUNT:   nxt_st.rdata[7:0] = tmr_count;
                EPWM_OFS_TCTRL:   nxt_st.rdata[6:0] = st_ff.tctrl;
                EPWM_OFS_PERIOD:  nxt_st.rdata[7:0] = st_ff.period;
                EPWM_OFS_DUTY:    nxt_st.rdata[7:0] = st_ff.duty_hi;
                EPWM_OFS_SHADOW:  nxt_st.rdata[7:0] = st_ff.shadow_hi;
                EPWM_OFS_MODE:    nxt_st.rdata[7:0] = st_ff.mode;
                EPWM_OFS_SDCTRL:  nxt_st.rdata[7:0] = {st_ff.sd_status,
                    st_ff.sd_src, st_ff.sd_ac, st_ff.sd_bd};
                EPWM_OFS_RESTART: nxt_st.rdata[7:0] = {st_ff.restart_en,
                    st_ff.dly};
                EPWM_OFS_FLAGS:
                    nxt_st.rdata[EPWM_FLAG_MATCH_BIT] = st_ff.match_flag;
                EPWM_OFS_PINDIR:  nxt_st.rdata[3:0] = st_ff.dir;
                default:          nxt_st.rdata      = 32'h0000_0000;
            endcase
        end
    end

    // Reset returns every pin to input and registers to reset values
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            st_ff       <= '0; // RL14
            st_ff.dir   <= EPWM_DIR_RESET;
            st_ff.mode  <= EPWM_REG_RESET;
        end
        else
            st_ff <= nxt_st;
    end

    assign pin_level_out = st_ff.pins;
    assign pin_oe_out    = st_ff.oe;

    // ==================================================================
    // Checks
    sequence sd_event_s;
        sd_cond;
    endsequence

    chk_sd_event_set: assert property (@(posedge core_clk_in) // RL18
        disable iff (rst_in)
        sd_event_s |=> st_ff.sd_status && shut)
        else $error("shutdown event did not set status");

    chk_sd_write_lock: assert property (@(posedge core_clk_in) // RL19
        disable iff (rst_in)
        sd_cond && wr_en && paddr_in == EPWM_OFS_SDCTRL |=> st_ff.sd_status)
        else $error("status cleared while trigger active");

    chk_auto_restart: assert property (@(posedge core_clk_in) // RL10
        disable iff (rst_in)
        st_ff.restart_en && st_ff.sd_status && !sd_cond && !wr_en
        |=> !st_ff.sd_status)
        else $error("auto restart did not clear status");

    chk_hold_release: assert property (@(posedge core_clk_in) // RL18
        disable iff (rst_in)
        $fell(st_ff.hold_shut) |-> $past(period_start))
        else $error("shutdown released mid period");

    chk_shut_pins: assert property (@(posedge core_clk_in) // RL8
        disable iff (rst_in)
        shut && pwm_on && st_ff.sd_ac == 2'b01
        |=> st_ff.pins[0] && st_ff.pins[2])
        else $error("pair a/c not at shutdown level");

    chk_shut_float: assert property (@(posedge core_clk_in) // RL17
        disable iff (rst_in)
        shut && pwm_on && st_ff.sd_ac[1] |=> !st_ff.oe[0] && !st_ff.oe[2])
        else $error("pair a/c driven in float state");

    chk_flag_raise: assert property (@(posedge core_clk_in) // RL20
        disable iff (rst_in)
        period_start |=> st_ff.match_flag ##0 tmr_count == 8'h00)
        else $error("match flag missing at period start");

    chk_pol_single: assert property (@(posedge core_clk_in) // RL4
        disable iff (rst_in)
        !shut && pwm_on && cfg == EPWM_CFG_SINGLE
        |=> st_ff.pins[0] == ($past(pwm_raw) ^ $past(st_ff.mode[1])))
        else $error("pin a polarity wrong");

    chk_reset_inputs: assert property (@(posedge core_clk_in) // RL14
        disable iff (rst_in)
        $fell(rst_in) |-> st_ff.dir == EPWM_DIR_RESET &&
            st_ff.oe == 4'h0 && !st_ff.sd_status)
        else $error("pins not inputs after reset");

endmodule // epwm_core

// ===== verif/epwm_bridge.sv
// Bridge switch model on the four PWM pins.
// Assumes pull-down resistors keep undriven gates off.
`timescale 1ns/100ps

module epwm_bridge
(
    // Pins from the unit
    input  wire logic [3:0] pin_level_in,
    input  wire logic [3:0] pin_oe_in,
    // Gate level seen by each switch
    output logic      [3:0] gate_out
);
    // A floating pin falls to the pull-down, so a switch never half-opens
    assign gate_out = pin_level_in & pin_oe_in;
endmodule // epwm_bridge

// ===== verif/tb.sv
// Self-checking bench: registers, duty, shutdown sources and states.
// Assumes a zero-wait APB slave and the pull-down bridge model.
`timescale 1ns/100ps

module tb import epwm_pkg::*;;
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic        c1 = 0, c2 = 0, flt_n = 1, er, pready, pslverr;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 0, prdata, rd, lf = 32'he3e7;
    logic [3:0]  lvl, oe, gate;
    int          err_count = 0, n_checks = 0, cyc = 0, hi, ex;

    // 40 MHz core clock
    always #12.5 clk = ~clk;

    epwm_core DUT (.core_clk_in(clk), .rst_in(rst), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .comp1_in(c1), .comp2_in(c2),
        .fault_n_in(flt_n), .pin_level_out(lvl), .pin_oe_out(oe));
    epwm_bridge bridge (.pin_level_in(lvl), .pin_oe_in(oe), .gate_out(gate));

    function automatic logic [31:0] nxt_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // One APB transfer; one idle edge first so psel never toggles twice
    task apb(input bit w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        // Only the bench timeout ends a wait for the slave
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(0, a, 0);
        chk(rd, exp);
    endtask

    task report_and_stop;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // A hang counts as a mismatch
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_count++;
            report_and_stop;
        end
    end

    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 0;
        // Reset values, then an unmapped word
        for (int i = 0; i < 10; i++)
            rdchk(8'(i * 4), i == 9 ? 32'hF : 32'h0);
        chk(oe, 4'h0);
        apb(0, 8'h28, 0);
        chk(er, 1'b1);
        chk(rd, 0);
        // Single output, duty 6 clocks of a 16-clock period, held shut
        apb(1, EPWM_OFS_PINDIR, 32'h0000_000F);
        apb(1, EPWM_OFS_PERIOD, 8'h03);
        apb(1, EPWM_OFS_DUTY, 8'h01);
        apb(1, EPWM_OFS_MODE, 8'h2C);
        apb(1, EPWM_OFS_SDCTRL, 8'h80);
        apb(1, EPWM_OFS_FLAGS, 0);
        apb(1, EPWM_OFS_TCTRL, 8'h04);
        rdchk(EPWM_OFS_MODE, 8'h2C);
        repeat (40) @(posedge clk);
        rdchk(EPWM_OFS_FLAGS, 8'h02);
        apb(1, EPWM_OFS_PINDIR, 0);
        apb(1, EPWM_OFS_SDCTRL, 0);
        repeat (20) @(posedge clk);
        hi = 0;
        repeat (64) @(posedge clk) hi += gate[0];
        chk(hi, 24);
        // Comparator 1 trips with auto-restart: a/c high, b/d low
        apb(1, EPWM_OFS_RESTART, 8'h80);
        apb(1, EPWM_OFS_SDCTRL, 8'h14);
        @(posedge clk) c1 <= 1;
        repeat (3) @(posedge clk);
        chk(gate, 4'h5);
        apb(1, EPWM_OFS_SDCTRL, 8'h14);
        rdchk(EPWM_OFS_SDCTRL, 8'h94);
        @(posedge clk) c1 <= 0;
        repeat (3) @(posedge clk);
        rdchk(EPWM_OFS_SDCTRL, 8'h14);
        // Forced shutdown with a/c floating
        apb(1, EPWM_OFS_RESTART, 0);
        apb(1, EPWM_OFS_SDCTRL, 8'h88);
        repeat (2) @(posedge clk);
        chk(oe, 4'hA);
        // Every source code against random comparator and pin levels
        for (int k = 0; k < 8; k++)
        begin
            lf = nxt_rand(lf);
            apb(1, EPWM_OFS_SDCTRL, 8'(k << 4));
            c1 <= lf[0];
            c2 <= lf[1];
            flt_n <= lf[2];
            repeat (3) @(posedge clk);
            ex = (k[0] & lf[0]) | (k[1] & lf[1]) | (k[2] & ~lf[2]);
            apb(0, EPWM_OFS_SDCTRL, 0);
            chk(rd[7], ex[0]);
            c1 <= 0;
            c2 <= 0;
            flt_n <= 1;
            apb(1, EPWM_OFS_SDCTRL, 0);
        end
        // Half bridge, one-count dead band: each turn-on loses 4 clocks
        apb(1, EPWM_OFS_RESTART, 8'h01);
        apb(1, EPWM_OFS_MODE, 8'hAC);
        repeat (40) @(posedge clk);
        hi = 0;
        ex = 0;
        repeat (64) @(posedge clk)
        begin
            hi += gate[0];
            ex += gate[1];
        end
        chk(hi, 8);
        chk(ex, 24);
        report_and_stop;
    end
endmodule // tb
